// file: common/lrsd_pkg.sv
// constants shared by the lcd row scan driver
package lrsd_pkg;

   // geometry
   localparam int ROWS = 160;
   localparam int HALF = 80;

   // drive level codes, two bits per row output
   localparam logic [1:0] LVL_TOP = 2'h0;
   localparam logic [1:0] LVL_UPPER_MID = 2'h1;
   localparam logic [1:0] LVL_LOWER_MID = 2'h2;
   localparam logic [1:0] LVL_LOWEST = 2'h3;

   // positions of the pin inputs in the synchroniser vector
   localparam int N_IN = 12;
   localparam int IN_DIR = 0;
   localparam int IN_MODE = 1;
   localparam int IN_BLANK_N = 2;
   localparam int IN_FRAME_POL = 3;
   localparam int IN_LSCLK = 4;
   localparam int IN_MON_CLK = 5;
   localparam int IN_MON_GATE = 6;
   localparam int IN_NAND_A = 7;
   localparam int IN_NAND_B = 8;
   localparam int IN_SCAN_A = 9;
   localparam int IN_SCAN_B = 10;
   localparam int IN_SCAN_2ND = 11;

   // register map, byte addresses
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_INT_STAT = 8'h08;
   localparam logic [7:0] REG_INT_MASK = 8'h0C;
   localparam logic [7:0] REG_HALT_LIMIT = 8'h10;

   // ctrl fields
   localparam int CTRL_SOFT_BLANK = 0;

   // status fields
   localparam int ST_HALTED = 0;
   localparam int ST_DIR = 1;
   localparam int ST_MODE = 2;
   localparam int ST_BLANK_N = 3;
   localparam int ST_FRAME_POL = 4;
   localparam int ST_SCAN_OUT = 5;

   // interrupt fields
   localparam int N_EV = 3;
   localparam int EV_HALT = 0;
   localparam int EV_RESUME = 1;
   localparam int EV_SCAN_IN = 2;

   // reset values
   localparam logic CTRL_RESET = 1'b0;
   localparam logic [2:0] INT_MASK_RESET = 3'h0;

   // halt detection time and its cycle count at the pclk rate
   localparam longint CLK_PERIOD_PS = 10000;
   localparam longint HALT_TIME_US = 35600;
   localparam longint HALT_CYCLES = (HALT_TIME_US * 1000000) / CLK_PERIOD_PS;

endpackage

// file: rtl/lrsd_row_scan_driver.sv
// row scan driver: bidirectional scan chain, level select, clock monitor, apb registers
`timescale 1ns/10ps
`default_nettype none

module lrsd_row_scan_driver #(
   parameter int unsigned HALT_CYCLES = 32'(lrsd_pkg::HALT_CYCLES)
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [lrsd_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic scan_dir_sel,
   input wire logic chain_mode_sel,
   input wire logic blank_n,
   input wire logic frame_polarity,
   input wire logic line_shift_clk,
   input wire logic scan_io_a_in,
   output logic scan_io_a_out,
   output logic scan_io_a_oe,
   input wire logic scan_io_b_in,
   output logic scan_io_b_out,
   output logic scan_io_b_oe,
   input wire logic second_scan_in,
   output logic [2*lrsd_pkg::ROWS-1:0] row_drive_out,
   input wire logic monitor_clk_in,
   input wire logic monitor_gate_in,
   output logic clk_fail_out,
   input wire logic nand_in_a,
   input wire logic nand_in_b,
   output logic nand_out
);

   typedef struct packed {
      logic [lrsd_pkg::N_IN-1:0] sync1_r;
      logic [lrsd_pkg::N_IN-1:0] sync2_r;
      logic [lrsd_pkg::N_IN-1:0] prev_r;
      logic [lrsd_pkg::ROWS-1:0] chain_r;
      logic [2*lrsd_pkg::ROWS-1:0] row_level_r;
      logic scan_a_out_r;
      logic scan_b_out_r;
      logic scan_a_oe_r;
      logic scan_b_oe_r;
      logic [31:0] halt_cnt_r;
      logic halted_r;
      logic clk_fail_r;
      logic nand_r;
      logic soft_blank_r;
      logic [31:0] halt_limit_r;
      logic [lrsd_pkg::N_EV-1:0] int_stat_r;
      logic [lrsd_pkg::N_EV-1:0] int_mask_r;
      logic [31:0] prdata_r;
      logic irq_r;
   } lrsd_state_t;

   lrsd_state_t state_r;
   lrsd_state_t state_nxt;

   logic [lrsd_pkg::N_IN-1:0] pins_raw;
   logic [lrsd_pkg::N_IN-1:0] pins;
   logic shift_fall;
   logic mon_edge;
   logic dir_high;
   logic two_chains;
   logic blank_eff_n;
   logic in_first;
   logic in_second;
   logic [lrsd_pkg::N_EV-1:0] events;
   logic wr_access;
   logic rd_setup;
   logic addr_hit;
   logic [31:0] status_word;

   assign pins_raw = {second_scan_in, scan_io_b_in, scan_io_a_in, nand_in_b, nand_in_a,
                      monitor_gate_in, monitor_clk_in, line_shift_clk, frame_polarity,
                      blank_n, chain_mode_sel, scan_dir_sel};

   // only the second stage is ever read downstream
   assign pins = state_r.sync2_r;

   always_comb
   begin
      state_nxt = state_r;
      shift_fall = 1'b0;
      mon_edge = 1'b0;
      dir_high = 1'b0;
      two_chains = 1'b0;
      blank_eff_n = 1'b0;
      in_first = 1'b0;
      in_second = 1'b0;
      events = '0;
      wr_access = 1'b0;
      rd_setup = 1'b0;
      addr_hit = 1'b0;
      status_word = '0;

      // input synchronisers
      state_nxt.sync1_r = pins_raw;
      state_nxt.sync2_r = state_r.sync1_r;
      state_nxt.prev_r = pins;

      dir_high = pins[lrsd_pkg::IN_DIR];
      two_chains = pins[lrsd_pkg::IN_MODE];
      shift_fall = state_r.prev_r[lrsd_pkg::IN_LSCLK] & ~pins[lrsd_pkg::IN_LSCLK];
      mon_edge = state_r.prev_r[lrsd_pkg::IN_MON_CLK] ^ pins[lrsd_pkg::IN_MON_CLK];

      // serial inputs: the idle pad is the input end of the chain
      in_first = dir_high ? pins[lrsd_pkg::IN_SCAN_B] : pins[lrsd_pkg::IN_SCAN_A];
      in_second = pins[lrsd_pkg::IN_SCAN_2ND];

      // the scan chain
      if (shift_fall)
      begin
         if (!dir_high)
         begin
            // upward: first bit travels toward row 159
            if (two_chains)
            begin
               state_nxt.chain_r[lrsd_pkg::HALF-1:0] =
                  {state_r.chain_r[lrsd_pkg::HALF-2:0], in_first};
               state_nxt.chain_r[lrsd_pkg::ROWS-1:lrsd_pkg::HALF] =
                  {state_r.chain_r[lrsd_pkg::ROWS-2:lrsd_pkg::HALF], in_second};
            end
            else
            begin
               state_nxt.chain_r = {state_r.chain_r[lrsd_pkg::ROWS-2:0], in_first};
            end
         end
         else
         begin
            // downward: first bit travels toward row 0
            if (two_chains)
            begin
               state_nxt.chain_r[lrsd_pkg::ROWS-1:lrsd_pkg::HALF] =
                  {in_first, state_r.chain_r[lrsd_pkg::ROWS-1:lrsd_pkg::HALF+1]};
               state_nxt.chain_r[lrsd_pkg::HALF-1:0] =
                  {in_second, state_r.chain_r[lrsd_pkg::HALF-1:1]};
            end
            else
            begin
               state_nxt.chain_r = {in_first, state_r.chain_r[lrsd_pkg::ROWS-1:1]};
            end
         end
         events[lrsd_pkg::EV_SCAN_IN] = in_first;
      end

      // cascade output: row 159 going up, row 0 going down; in two-chain mode the last stage of the second chain
      state_nxt.scan_a_oe_r = dir_high;
      state_nxt.scan_b_oe_r = ~dir_high;
      state_nxt.scan_b_out_r = dir_high ? 1'b0 : state_nxt.chain_r[lrsd_pkg::ROWS-1];
      state_nxt.scan_a_out_r = dir_high ? state_nxt.chain_r[0] : 1'b0;

      // level select, computed from the chain as it stands after this edge
      blank_eff_n = pins[lrsd_pkg::IN_BLANK_N] & ~state_r.soft_blank_r;
      for (int i = 0; i < lrsd_pkg::ROWS; i++)
      begin
         if (!blank_eff_n)
         begin
            state_nxt.row_level_r[2*i +: 2] = lrsd_pkg::LVL_LOWEST;
         end
         else if (state_nxt.chain_r[i])
         begin
            state_nxt.row_level_r[2*i +: 2] = pins[lrsd_pkg::IN_FRAME_POL] ?
               lrsd_pkg::LVL_LOWEST : lrsd_pkg::LVL_TOP;
         end
         else
         begin
            state_nxt.row_level_r[2*i +: 2] = pins[lrsd_pkg::IN_FRAME_POL] ?
               lrsd_pkg::LVL_UPPER_MID : lrsd_pkg::LVL_LOWER_MID;
         end
      end

      // halt detector: any monitor clock edge restarts the watch window
      if (mon_edge)
      begin
         state_nxt.halt_cnt_r = '0;
         state_nxt.halted_r = 1'b0;
      end
      else if (state_r.halt_cnt_r >= state_r.halt_limit_r)
      begin
         state_nxt.halted_r = 1'b1;
      end
      else
      begin
         state_nxt.halt_cnt_r = state_r.halt_cnt_r + 32'h00000001;
      end
      events[lrsd_pkg::EV_HALT] = state_nxt.halted_r & ~state_r.halted_r;
      events[lrsd_pkg::EV_RESUME] = state_r.halted_r & ~state_nxt.halted_r;

      // gate low (its undriven state) also holds the fail output low
      state_nxt.clk_fail_r = ~state_nxt.halted_r & pins[lrsd_pkg::IN_MON_GATE];
      state_nxt.nand_r = ~(pins[lrsd_pkg::IN_NAND_A] & pins[lrsd_pkg::IN_NAND_B]);

      // apb slave, zero wait states
      addr_hit = (paddr == lrsd_pkg::REG_CTRL) || (paddr == lrsd_pkg::REG_STATUS) ||
                 (paddr == lrsd_pkg::REG_INT_STAT) || (paddr == lrsd_pkg::REG_INT_MASK) ||
                 (paddr == lrsd_pkg::REG_HALT_LIMIT);
      wr_access = psel & penable & pwrite & addr_hit;
      rd_setup = psel & ~penable & ~pwrite;

      status_word[lrsd_pkg::ST_HALTED] = state_r.halted_r;
      status_word[lrsd_pkg::ST_DIR] = dir_high;
      status_word[lrsd_pkg::ST_MODE] = two_chains;
      status_word[lrsd_pkg::ST_BLANK_N] = pins[lrsd_pkg::IN_BLANK_N];
      status_word[lrsd_pkg::ST_FRAME_POL] = pins[lrsd_pkg::IN_FRAME_POL];
      status_word[lrsd_pkg::ST_SCAN_OUT] = dir_high ? state_r.scan_a_out_r : state_r.scan_b_out_r;

      // read data is captured in the setup cycle so it stands through the access
      if (rd_setup)
      begin
         unique case (paddr)
            lrsd_pkg::REG_CTRL: state_nxt.prdata_r = {31'h00000000, state_r.soft_blank_r};
            lrsd_pkg::REG_STATUS: state_nxt.prdata_r = status_word;
            lrsd_pkg::REG_INT_STAT: state_nxt.prdata_r = {29'h00000000, state_r.int_stat_r};
            lrsd_pkg::REG_INT_MASK: state_nxt.prdata_r = {29'h00000000, state_r.int_mask_r};
            lrsd_pkg::REG_HALT_LIMIT: state_nxt.prdata_r = state_r.halt_limit_r;
            default: state_nxt.prdata_r = 32'h00000000;
         endcase
      end

      if (wr_access)
      begin
         unique case (paddr)
            lrsd_pkg::REG_CTRL: state_nxt.soft_blank_r = pwdata[lrsd_pkg::CTRL_SOFT_BLANK];
            lrsd_pkg::REG_INT_MASK: state_nxt.int_mask_r = pwdata[lrsd_pkg::N_EV-1:0];
            lrsd_pkg::REG_HALT_LIMIT: state_nxt.halt_limit_r = pwdata;
            default: state_nxt.int_mask_r = state_r.int_mask_r;
         endcase
      end

      // write one to clear; an event in the same cycle keeps its bit set
      state_nxt.int_stat_r = state_r.int_stat_r;
      if (wr_access && (paddr == lrsd_pkg::REG_INT_STAT))
      begin
         state_nxt.int_stat_r = state_r.int_stat_r & ~pwdata[lrsd_pkg::N_EV-1:0];
      end
      state_nxt.int_stat_r = state_nxt.int_stat_r | events;
      state_nxt.irq_r = |(state_nxt.int_stat_r & state_nxt.int_mask_r);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r.sync1_r <= '0;
         state_r.sync2_r <= '0;
         state_r.prev_r <= '0;
         state_r.chain_r <= '0;
         state_r.row_level_r <= {lrsd_pkg::ROWS{lrsd_pkg::LVL_LOWEST}};
         state_r.scan_a_out_r <= 1'b0;
         state_r.scan_b_out_r <= 1'b0;
         state_r.scan_a_oe_r <= 1'b0;
         state_r.scan_b_oe_r <= 1'b0;
         state_r.halt_cnt_r <= '0;
         state_r.halted_r <= 1'b0;
         state_r.clk_fail_r <= 1'b0;
         state_r.nand_r <= 1'b1;
         state_r.soft_blank_r <= lrsd_pkg::CTRL_RESET;
         state_r.halt_limit_r <= HALT_CYCLES;
         state_r.int_stat_r <= '0;
         state_r.int_mask_r <= lrsd_pkg::INT_MASK_RESET;
         state_r.prdata_r <= '0;
         state_r.irq_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign prdata = state_r.prdata_r;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_hit;
   assign irq = state_r.irq_r;
   assign scan_io_a_out = state_r.scan_a_out_r;
   assign scan_io_a_oe = state_r.scan_a_oe_r;
   assign scan_io_b_out = state_r.scan_b_out_r;
   assign scan_io_b_oe = state_r.scan_b_oe_r;
   assign row_drive_out = state_r.row_level_r;
   assign clk_fail_out = state_r.clk_fail_r;
   assign nand_out = state_r.nand_r;

endmodule // lrsd_row_scan_driver

`default_nettype wire

// file: test/lrsd_ctrl_model.sv
// panel controller model: line shift clock and scan pulses
`timescale 1ns/10ps
`default_nettype none
module lrsd_ctrl_model
(
   input wire logic pclk,
   output logic line_shift_clk,
   output logic scan_data,
   output logic second_data
);
   initial line_shift_clk = 1'b1;
   initial scan_data = 1'b0;
   initial second_data = 1'b0;
   // hold 1 is the fastest the pin sync accepts, larger means a slow controller
   task automatic shift(input logic a, input logic s, input int hold);
      @(posedge pclk);
      scan_data <= a;
      second_data <= s;
      repeat (hold) @(posedge pclk);
      line_shift_clk <= 1'b0;
      repeat (hold) @(posedge pclk);
      // hold time over: inverse, so a late sample is caught
      scan_data <= ~a;
      second_data <= ~s;
      line_shift_clk <= 1'b1;
   endtask
endmodule // lrsd_ctrl_model
`default_nettype wire

// file: test/lrsd_row_scan_driver_sva.sv
// port assertions for the row scan driver
`timescale 1ns/10ps
`default_nettype none
module lrsd_row_scan_driver_sva
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [lrsd_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scan_dir_sel,
   input wire logic blank_n,
   input wire logic frame_polarity,
   input wire logic scan_io_a_out,
   input wire logic scan_io_a_oe,
   input wire logic scan_io_b_out,
   input wire logic scan_io_b_oe,
   input wire logic [2*lrsd_pkg::ROWS-1:0] row_drive_out,
   input wire logic monitor_gate_in,
   input wire logic clk_fail_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_blank_all_lowest: assert property ((!blank_n) [*6] |-> row_drive_out == {160{2'h3}})
      else $error("rows not lowest while blanked");
   a_pol_low_levels: assert property ((blank_n && !frame_polarity) [*6] |->
      row_drive_out[1:0] inside {2'h0, 2'h2} && row_drive_out[319:318] inside {2'h0, 2'h2})
      else $error("bad level with polarity low");
   a_pol_high_levels: assert property ((blank_n && frame_polarity) [*6] |->
      row_drive_out[1:0] inside {2'h1, 2'h3} && row_drive_out[319:318] inside {2'h1, 2'h3})
      else $error("bad level with polarity high");
   a_dir_low_out: assert property ((!scan_dir_sel && blank_n && frame_polarity) [*6] |->
      scan_io_b_oe && !scan_io_a_oe && scan_io_b_out == (row_drive_out[319:318] == 2'h3))
      else $error("pin b not carrying row 159");
   a_dir_high_out: assert property ((scan_dir_sel && blank_n && frame_polarity) [*6] |->
      scan_io_a_oe && !scan_io_b_oe && scan_io_a_out == (row_drive_out[1:0] == 2'h3))
      else $error("pin a not carrying row 0");
   a_gate_forces_fail: assert property ((!monitor_gate_in) [*5] |=> !clk_fail_out)
      else $error("fail output high with gate low");
   a_fail_rise_gate: assert property ($rose(clk_fail_out) |->
      $past(monitor_gate_in, 3) || $past(monitor_gate_in, 4))
      else $error("fail output released without gate");
   a_apb_answer: assert property (psel && penable |->
      pready && pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
      else $error("bad apb answer");
endmodule // lrsd_row_scan_driver_sva
bind lrsd_row_scan_driver lrsd_row_scan_driver_sva lrsd_row_scan_driver_sva_i (
   .pclk(pclk),
   .presetn(presetn),
   .paddr(paddr),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .pslverr(pslverr),
   .scan_dir_sel(scan_dir_sel),
   .blank_n(blank_n),
   .frame_polarity(frame_polarity),
   .scan_io_a_out(scan_io_a_out),
   .scan_io_a_oe(scan_io_a_oe),
   .scan_io_b_out(scan_io_b_out),
   .scan_io_b_oe(scan_io_b_oe),
   .row_drive_out(row_drive_out),
   .monitor_gate_in(monitor_gate_in),
   .clk_fail_out(clk_fail_out)
);
`default_nettype wire

// file: test/lrsd_row_scan_driver_tb.sv
// self-checking bench for the row scan driver
`timescale 1ns/10ps
`default_nettype none
module lrsd_row_scan_driver_tb;
   typedef struct packed {logic bn; logic fp; logic [1:0] r0; logic [1:0] r1;} lrsd_lvl_t;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, irq, scan_dir_sel, chain_mode_sel, blank_n, err;
   logic frame_polarity, line_shift_clk, scan_io_a_out, scan_io_a_oe, scan_io_b_out, scan_io_b_oe, scan_data;
   logic monitor_clk_in, monitor_gate_in, clk_fail_out, nand_in_a, nand_in_b, nand_out, second_scan_in, mon_run;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [319:0] row_drive_out;
   int bad_count = 0;
   int comparisons = 0;
   lrsd_lvl_t tbl [4];
   wire logic pin_a = scan_io_a_oe ? scan_io_a_out : scan_data;
   wire logic pin_b = scan_io_b_oe ? scan_io_b_out : scan_data;
   lrsd_row_scan_driver #(.HALT_CYCLES(50)) lrsd_row_scan_driver_i (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .scan_dir_sel(scan_dir_sel),
      .chain_mode_sel(chain_mode_sel), .blank_n(blank_n), .frame_polarity(frame_polarity),
      .line_shift_clk(line_shift_clk), .scan_io_a_in(pin_a), .scan_io_a_out(scan_io_a_out),
      .scan_io_a_oe(scan_io_a_oe), .scan_io_b_in(pin_b), .scan_io_b_out(scan_io_b_out),
      .scan_io_b_oe(scan_io_b_oe), .second_scan_in(second_scan_in), .row_drive_out(row_drive_out),
      .monitor_clk_in(monitor_clk_in), .monitor_gate_in(monitor_gate_in), .clk_fail_out(clk_fail_out),
      .nand_in_a(nand_in_a), .nand_in_b(nand_in_b), .nand_out(nand_out));
   lrsd_ctrl_model lrsd_ctrl_model_i (.pclk(pclk), .line_shift_clk(line_shift_clk), .scan_data(scan_data),
      .second_data(second_scan_in));
   always #5 pclk = ~pclk;
   always @(posedge pclk) if (mon_run) monitor_clk_in <= ~monitor_clk_in;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic run(input logic a, input logic s, input int n);
      lrsd_ctrl_model_i.shift(a, s, 4);
      repeat (n - 1) lrsd_ctrl_model_i.shift(1'b0, 1'b0, 3);
      settle(6);
   endtask
   function automatic logic [31:0] row(input int i);
      return 32'(row_drive_out[2*i+:2]);
   endfunction
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      finish_test;
   end
   initial
   begin
      tbl[0] = '{1'b1, 1'b1, lrsd_pkg::LVL_LOWEST, lrsd_pkg::LVL_UPPER_MID};
      tbl[1] = '{1'b1, 1'b0, lrsd_pkg::LVL_TOP, lrsd_pkg::LVL_LOWER_MID};
      tbl[2] = '{1'b0, 1'b1, lrsd_pkg::LVL_LOWEST, lrsd_pkg::LVL_LOWEST};
      tbl[3] = '{1'b0, 1'b0, lrsd_pkg::LVL_LOWEST, lrsd_pkg::LVL_LOWEST};
      {presetn, psel, penable, pwrite, scan_dir_sel, chain_mode_sel, nand_in_a, nand_in_b, monitor_clk_in} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      blank_n = 1'b0;
      {frame_polarity, monitor_gate_in, mon_run} = 3'h7;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      chk(32'(row_drive_out === {160{lrsd_pkg::LVL_LOWEST}}), 1);
      chk(32'(clk_fail_out), 0);
      @(posedge pclk);
      presetn <= 1'b1;
      run(1'b1, 1'b0, 1);
      foreach (tbl[i])
      begin
         @(posedge pclk);
         blank_n <= tbl[i].bn;
         frame_polarity <= tbl[i].fp;
         settle(6);
         chk(row(0), 32'(tbl[i].r0));
         chk(row(1), 32'(tbl[i].r1));
      end
      @(posedge pclk);
      blank_n <= 1'b1;
      frame_polarity <= 1'b1;
      run(1'b1, 1'b0, 160);
      chk(row(159), 32'(lrsd_pkg::LVL_LOWEST));
      chk(row(158), 32'(lrsd_pkg::LVL_UPPER_MID));
      chk(32'(scan_io_b_out), 1);
      @(posedge pclk);
      scan_dir_sel <= 1'b1;
      run(1'b1, 1'b0, 160);
      chk(row(0), 32'(lrsd_pkg::LVL_LOWEST));
      chk(32'(scan_io_a_out), 1);
      // soft blank with polarity high and a one at row 0 keeps the port checks valid
      apb(1'b1, lrsd_pkg::REG_CTRL, 32'h1);
      settle(2);
      chk(row(1), 32'(lrsd_pkg::LVL_LOWEST));
      apb(1'b0, lrsd_pkg::REG_CTRL, 32'h0);
      chk(rd, 1);
      apb(1'b1, lrsd_pkg::REG_CTRL, 32'h0);
      settle(2);
      chk(row(1), 32'(lrsd_pkg::LVL_UPPER_MID));
      // old bit at row 0 drops off row 79, never crosses into row 80
      @(posedge pclk);
      chain_mode_sel <= 1'b1;
      scan_dir_sel <= 1'b0;
      run(1'b1, 1'b1, 80);
      chk(row(79), 32'(lrsd_pkg::LVL_LOWEST));
      chk(row(80), 32'(lrsd_pkg::LVL_UPPER_MID));
      chk(row(159), 32'(lrsd_pkg::LVL_LOWEST));
      chk(32'(clk_fail_out), 1);
      apb(1'b0, lrsd_pkg::REG_INT_STAT, 32'h0);
      chk(rd, 32'h4);
      apb(1'b1, lrsd_pkg::REG_INT_STAT, 32'h7);
      @(posedge pclk);
      mon_run <= 1'b0;
      settle(70);
      chk(32'(clk_fail_out), 0);
      chk(32'(irq), 0);
      @(posedge pclk);
      blank_n <= clk_fail_out;
      settle(6);
      chk(row(80), 32'(lrsd_pkg::LVL_LOWEST));
      apb(1'b1, lrsd_pkg::REG_INT_MASK, 32'h1);
      settle(3);
      chk(32'(irq), 1);
      apb(1'b0, lrsd_pkg::REG_INT_STAT, 32'h0);
      chk(rd & 32'h1, 1);
      apb(1'b1, lrsd_pkg::REG_INT_STAT, 32'h1);
      settle(3);
      chk(32'(irq), 0);
      @(posedge pclk);
      mon_run <= 1'b1;
      settle(10);
      chk(32'(clk_fail_out), 1);
      @(posedge pclk);
      blank_n <= clk_fail_out;
      apb(1'b0, lrsd_pkg::REG_INT_STAT, 32'h0);
      chk(rd, 32'h2);
      @(posedge pclk);
      monitor_gate_in <= 1'b0;
      settle(6);
      chk(32'(clk_fail_out), 0);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 0);
      chk(32'(err), 1);
      apb(1'b0, lrsd_pkg::REG_HALT_LIMIT, 32'h0);
      chk(rd, 50);
      // halted 0, dir 0, two chains, blank_n 1, polarity 1, serial out 1
      apb(1'b0, lrsd_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h3C);
      @(posedge pclk);
      {nand_in_a, nand_in_b} <= 2'h3;
      settle(6);
      chk(32'(nand_out), 0);
      @(posedge pclk);
      mon_run <= 1'b0;
      @(posedge pclk);
      monitor_clk_in <= 1'b0;
      nand_in_a <= 1'b0;
      settle(70);
      chk(32'(nand_out), 1);
      chk(32'(clk_fail_out), 0);
      // reset in mid-run must bring the limit back to its default
      apb(1'b1, lrsd_pkg::REG_HALT_LIMIT, 32'h64);
      apb(1'b0, lrsd_pkg::REG_HALT_LIMIT, 32'h0);
      chk(rd, 32'h64);
      @(posedge pclk);
      presetn <= 1'b0;
      settle(2);
      chk(32'(row_drive_out === {160{lrsd_pkg::LVL_LOWEST}}), 1);
      chk(32'({irq, clk_fail_out, scan_io_a_oe, scan_io_b_oe, nand_out}), 1);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, lrsd_pkg::REG_HALT_LIMIT, 32'h0);
      chk(rd, 50);
      finish_test;
   end
endmodule // lrsd_row_scan_driver_tb
`default_nettype wire
